// ### rtl/fcdo_params.svh
// constants of the flash command decoder
`ifndef FCDO_PARAMS_SVH
`define FCDO_PARAMS_SVH
`define FCDO_SEC_LSB   13
`define FCDO_OFF_555   13'h0555
`define FCDO_OFF_2AA   13'h02AA
`define FCDO_OFF_000   13'h0000
`define FCDO_LOW_X55   8'h55
`define FCDO_C_LOAD    8'h25
`define FCDO_C_COMMIT  8'h29
`define FCDO_C_ERASE   8'h80
`define FCDO_C_SECTOR  8'h30
`define FCDO_C_CHIP    8'h10
`define FCDO_C_STATUS  8'h70
`define FCDO_C_CLEAR   8'h71
`define FCDO_C_SUSPEND 8'hB0
`define FCDO_C_BLANK   8'h33
`define FCDO_C_PROTECT 8'h60
`define FCDO_C_RANGE   8'h61
`define FCDO_C_ID      8'h90
`define FCDO_C_QUERY   8'h98
`define FCDO_C_OTP     8'h88
`define FCDO_C_EXIT    8'hF0
`define FCDO_BUF_MAX   16'h001F
`define FCDO_OTP_UPPER 8'h80
`define FCDO_SERIAL_N  8'h08
`define FCDO_ERASED    16'hFFFF
`define FCDO_ST_READY  7
`define FCDO_ST_PFAIL  4
`define FCDO_ST_PROT   1
`define FCDO_LK_FACT   1
`define FCDO_LK_CUST   0
`endif

// ### rtl/fcdo_pkg.sv
// types shared by the flash command decoder
package fcdo_pkg;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_COUNT  = 4'h1,
		ST_LOAD   = 4'h3,
		ST_CONFIRM = 4'h2,
		ST_COMMIT = 4'h6,
		ST_ERASE  = 4'h7,
		ST_PROT1  = 4'h5,
		ST_PROT2  = 4'h4,
		ST_RANGE  = 4'hC
	} fcdo_state_t;
	typedef enum logic [2:0] {
		MODE_ARRAY = 3'h0,
		MODE_ID    = 3'h1,
		MODE_CFI   = 3'h3,
		MODE_OTP   = 3'h2
	} fcdo_mode_t;
endpackage

// ### rtl/fcdo_bus.sv
// bus cycle capture: address on later falling edge, data on first rising edge
`timescale 1ns/1ps
`default_nettype none
module fcdo_bus #(
	parameter int ADDR_W = 23
) (
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              ce_in,
	input  wire logic              ce_n_in,
	input  wire logic              we_n_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [15:0]       dq_in,
	output logic                   wr_out,
	output logic [ADDR_W-1:0]      addr_out,
	output logic [15:0]            data_out
);
	typedef struct packed {
		logic              act;
		logic [ADDR_W-1:0] addr;
		logic [15:0]       data;
	} fcdo_bus_t;
	fcdo_bus_t s, next_s;
	logic active;

	assign active = !ce_n_in && !we_n_in;
	always_comb begin
		next_s = s;
		next_s.act = active;
		if (active && !s.act)
			next_s.addr = addr_in;
		if (active)
			next_s.data = dq_in;
	end
	always_ff @(posedge clk_in) begin
		if (rst_in)
			s <= '0;
		else if (ce_in)
			s <= next_s;
	end
	// first strobe to rise ends the cycle; last sampled data is taken
	assign wr_out   = ce_in && s.act && !active;
	assign addr_out = s.addr;
	assign data_out = s.data;

	addr_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && s.act && active |=> $stable(addr_out))
		else $error("address moved during strobe");
	data_last_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_out && $past(ce_in) |-> data_out == $past(dq_in))
		else $error("data not from last strobe sample");
endmodule
`default_nettype wire

// ### rtl/fcdo_otp.sv
// secured one-time-programmable region with serial id and lock bits
`timescale 1ns/1ps
`default_nettype none
`include "fcdo_params.svh"
module fcdo_otp #(
	parameter bit           FACTORY_LOCKED = 1'b1,
	parameter bit           EXPRESS        = 1'b0,
	parameter logic [127:0] SERIAL_ID      = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978
) (
	input  wire logic       clk_in,
	input  wire logic       por_in,
	input  wire logic       ce_in,
	input  wire logic       wr_in,
	input  wire logic [7:0] waddr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic [7:0] raddr_in,
	input  wire logic [1:0] lock_set_in,
	output logic [15:0]     rdata_out,
	output logic            reject_out,
	output logic            fail_out,
	output logic [1:0]      lock_out
);
	// serial id value is arbitrary
	typedef struct packed {
		logic [1:0] lock;
		logic       fail;
	} fcdo_otp_t;
	fcdo_otp_t s, next_s;
	logic [15:0] mem [256];
	logic upper_w, upper_r, take;
	logic [15:0] merged;

	assign upper_w = waddr_in >= `FCDO_OTP_UPPER;
	assign upper_r = raddr_in >= `FCDO_OTP_UPPER;
	assign reject_out = wr_in && (upper_w ? (s.lock[`FCDO_LK_CUST] ||
		(FACTORY_LOCKED && !EXPRESS)) : s.lock[`FCDO_LK_FACT]);
	assign take = wr_in && !reject_out;
	assign merged = mem[waddr_in] & wdata_in;

	always_comb begin
		next_s = s;
		next_s.lock = s.lock | lock_set_in;
		// merged never holds a one where a zero was asked, so no write counts as error
		next_s.fail = take && |(merged & ~wdata_in);
	end
	always_ff @(posedge clk_in) begin
		if (por_in) begin
			s.lock <= {FACTORY_LOCKED, 1'b0};
			s.fail <= 1'b0;
		end else if (ce_in) begin
			s <= next_s;
		end
	end
	always_ff @(posedge clk_in) begin
		if (por_in) begin
			for (int i = 0; i < 256; i++)
				mem[i] <= `FCDO_ERASED;
		end else if (ce_in && take) begin
			mem[waddr_in] <= merged;
		end
	end
	always_comb begin
		rdata_out = mem[raddr_in];
		if (raddr_in < `FCDO_SERIAL_N)
			rdata_out = SERIAL_ID[{raddr_in[2:0], 4'h0} +: 16];
		else if (upper_r && FACTORY_LOCKED && !EXPRESS)
			rdata_out = `FCDO_ERASED;
	end
	assign lock_out = s.lock;
	assign fail_out = s.fail;

	lock_keep_a: assert property (@(posedge clk_in) disable iff (por_in)
		s.lock != 2'h0 |=> (s.lock & $past(s.lock)) == $past(s.lock))
		else $error("lock bit cleared");
	lower_reject_a: assert property (@(posedge clk_in) disable iff (por_in)
		wr_in && !upper_w && lock_out[`FCDO_LK_FACT] |-> reject_out ##1 !fail_out)
		else $error("factory range write not rejected");
endmodule
`default_nettype wire

// ### rtl/fcdo_decoder.sv
// command sequence decoder of a multiplexed-bus flash with secured region
`timescale 1ns/1ps
`default_nettype none
`include "fcdo_params.svh"
module fcdo_decoder #(
	parameter int           ADDR_W         = 23,
	parameter bit           FACTORY_LOCKED = 1'b1,
	parameter bit           EXPRESS        = 1'b0,
	parameter logic [127:0] SERIAL_ID      = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978
) (
	input  wire logic                   CLOCK_IN,
	input  wire logic                   RESET_IN,
	input  wire logic                   POWER_ON_IN,
	input  wire logic                   CLOCK_EN_IN,
	input  wire logic                   CE_N_IN,
	input  wire logic                   WE_N_IN,
	input  wire logic                   OE_N_IN,
	input  wire logic [ADDR_W-1:0]      ADDR_IN,
	input  wire logic [15:0]            DQ_IN,
	input  wire logic [15:0]            ARRAY_DATA_IN,
	input  wire logic                   BUSY_IN,
	input  wire logic                   SECTOR_PROTECTED_IN,
	input  wire logic                   PROGRAM_FAIL_IN,
	input  wire logic [1:0]             OTP_LOCK_SET_IN,
	output logic [15:0]                 DQ_OUT,
	output logic                        DQ_OE_OUT,
	output fcdo_pkg::fcdo_mode_t        MODE_OUT,
	output logic [ADDR_W-14:0]          SECTOR_OUT,
	output logic [ADDR_W-14:0]          RANGE_LOW_OUT,
	output logic                        BUF_WR_OUT,
	output logic [ADDR_W-1:0]           BUF_ADDR_OUT,
	output logic [15:0]                 BUF_DATA_OUT,
	output logic [4:0]                  BUF_COUNT_OUT,
	output logic                        PROGRAM_OUT,
	output logic                        ERASE_SECTOR_OUT,
	output logic                        ERASE_CHIP_OUT,
	output logic                        SUSPEND_OUT,
	output logic                        RESUME_OUT,
	output logic                        BLANK_CHECK_OUT,
	output logic                        PROTECT_OUT,
	output logic                        LOCK_RANGE_OUT,
	output logic [7:0]                  STATUS_OUT,
	output logic [1:0]                  OTP_LOCK_OUT
);
	import fcdo_pkg::*;
	localparam int SEC_W = ADDR_W - `FCDO_SEC_LSB;

	typedef struct packed {
		fcdo_state_t       st;
		fcdo_mode_t        mode;
		logic              stat_pend;
		logic [SEC_W-1:0]  sector;
		logic [SEC_W-1:0]  range_lo;
		logic              range_used;
		logic [4:0]        n;
		logic [4:0]        idx;
		logic              fail_prot;
		logic              fail_prog;
		logic [15:0]       dq;
		logic              dq_oe;
		logic              rd_act;
		logic              prog;
		logic              ers;
		logic              chip;
		logic              susp;
		logic              res;
		logic              blank;
		logic              prot;
		logic              lrange;
		logic              bwr;
		logic [ADDR_W-1:0] baddr;
		logic [15:0]       bdata;
	} fcdo_dec_t;
	fcdo_dec_t s, next_s;

	logic              w;
	logic [ADDR_W-1:0] wa;
	logic [15:0]       wd;
	logic [7:0]        code;
	logic [12:0]       off;
	logic [SEC_W-1:0]  sec;
	logic              same, rd, otp_rd, in_otp;
	logic              otp_wr, otp_rej, otp_fail, clr, set_prot, set_prog;
	logic [15:0]       otp_q;
	logic [23:0]       buf_q;
	logic [23:0]       buf_mem [32];

	fcdo_bus #(
		.ADDR_W (ADDR_W)
	) u_bus (
		.clk_in   (CLOCK_IN),
		.rst_in   (RESET_IN),
		.ce_in    (CLOCK_EN_IN),
		.ce_n_in  (CE_N_IN),
		.we_n_in  (WE_N_IN),
		.addr_in  (ADDR_IN),
		.dq_in    (DQ_IN),
		.wr_out   (w),
		.addr_out (wa),
		.data_out (wd)
	);

	// region storage survives hardware reset; only power-on restores it
	fcdo_otp #(
		.FACTORY_LOCKED (FACTORY_LOCKED),
		.EXPRESS        (EXPRESS),
		.SERIAL_ID      (SERIAL_ID)
	) u_otp (
		.clk_in      (CLOCK_IN),
		.por_in      (POWER_ON_IN),
		.ce_in       (CLOCK_EN_IN),
		.wr_in       (otp_wr),
		.waddr_in    (buf_q[23:16]),
		.wdata_in    (buf_q[15:0]),
		.raddr_in    (ADDR_IN[7:0]),
		.lock_set_in (OTP_LOCK_SET_IN),
		.rdata_out   (otp_q),
		.reject_out  (otp_rej),
		.fail_out    (otp_fail),
		.lock_out    (OTP_LOCK_OUT)
	);

	assign code   = wd[7:0];
	assign off    = wa[`FCDO_SEC_LSB-1:0];
	assign sec    = wa[ADDR_W-1:`FCDO_SEC_LSB];
	assign same   = sec == s.sector;
	assign in_otp = s.mode == MODE_OTP;
	assign rd     = !CE_N_IN && !OE_N_IN && WE_N_IN;
	// region overlays sector zero only, and never during an operation
	assign otp_rd = in_otp && !BUSY_IN && ADDR_IN[ADDR_W-1:`FCDO_SEC_LSB] == '0;
	assign otp_wr = s.st == ST_COMMIT;
	assign buf_q  = buf_mem[s.idx];
	assign clr    = w && s.st == ST_IDLE && off == `FCDO_OFF_555 && code == `FCDO_C_CLEAR;

	always_ff @(posedge CLOCK_IN) begin
		if (CLOCK_EN_IN && w && s.st == ST_LOAD && in_otp)
			buf_mem[s.idx] <= {wa[7:0], wd};
	end

	always_comb begin
		next_s = s;
		set_prot = 1'b0;
		set_prog = otp_fail || PROGRAM_FAIL_IN;
		{next_s.prog, next_s.ers, next_s.chip, next_s.susp} = 4'h0;
		{next_s.res, next_s.blank, next_s.prot, next_s.lrange, next_s.bwr} = 5'h00;
		if (otp_wr) begin
			set_prot = otp_rej;
			if (s.idx == s.n)
				next_s.st = ST_IDLE;
			else
				next_s.idx = s.idx + 5'h01;
		end else if (w) begin
			next_s.st = ST_IDLE;
			case (s.st)
				ST_IDLE: begin
					if (code == `FCDO_C_EXIT) begin
						next_s.mode = MODE_ARRAY;
						next_s.stat_pend = 1'b0;
					end else if (code == `FCDO_C_SUSPEND) begin
						next_s.susp = 1'b1;
					end else if (off == `FCDO_OFF_555 && code == `FCDO_C_LOAD) begin
						next_s.sector = sec;
						next_s.st = ST_COUNT;
					end else if (off == `FCDO_OFF_555 && code == `FCDO_C_ERASE) begin
						next_s.sector = sec;
						next_s.st = ST_ERASE;
					end else if (off == `FCDO_OFF_555 && code == `FCDO_C_STATUS) begin
						next_s.stat_pend = 1'b1;
					end else if (off == `FCDO_OFF_555 && code == `FCDO_C_CLEAR) begin
						next_s.stat_pend = s.stat_pend;
					end else if (off == `FCDO_OFF_555 && code == `FCDO_C_BLANK) begin
						next_s.sector = sec;
						next_s.blank = 1'b1;
					end else if (off == `FCDO_OFF_555 && code == `FCDO_C_OTP) begin
						if (!BUSY_IN)
							next_s.mode = MODE_OTP;
					end else if (off == `FCDO_OFF_555 && code == `FCDO_C_PROTECT) begin
						next_s.st = ST_PROT1;
					end else if (off == `FCDO_OFF_000 && code == `FCDO_C_SECTOR) begin
						next_s.sector = sec;
						next_s.res = 1'b1;
					end else if (wa[7:0] == `FCDO_LOW_X55 && code == `FCDO_C_ID) begin
						next_s.mode = MODE_ID;
					end else if (wa[7:0] == `FCDO_LOW_X55 && code == `FCDO_C_QUERY) begin
						next_s.mode = MODE_CFI;
					end else begin
						next_s.mode = MODE_ARRAY;
					end
				end
				ST_COUNT: begin
					// a count above the buffer would run past its 32 entries
					if (off == `FCDO_OFF_2AA && same && wd <= `FCDO_BUF_MAX) begin
						next_s.n = wd[4:0];
						next_s.idx = 5'h00;
						next_s.st = ST_LOAD;
					end else begin
						next_s.mode = MODE_ARRAY;
					end
				end
				ST_LOAD: begin
					if (same) begin
						next_s.bwr = !in_otp;
						next_s.baddr = wa;
						next_s.bdata = wd;
						if (s.idx == s.n) begin
							next_s.st = ST_CONFIRM;
						end else begin
							next_s.idx = s.idx + 5'h01;
							next_s.st = ST_LOAD;
						end
					end else begin
						next_s.mode = MODE_ARRAY;
					end
				end
				ST_CONFIRM: begin
					if (off == `FCDO_OFF_555 && same && code == `FCDO_C_COMMIT) begin
						if (in_otp) begin
							next_s.idx = 5'h00;
							next_s.st = ST_COMMIT;
						end else if (SECTOR_PROTECTED_IN) begin
							set_prot = 1'b1;
						end else begin
							next_s.prog = 1'b1;
						end
					end else begin
						next_s.mode = MODE_ARRAY;
					end
				end
				ST_ERASE: begin
					if (off == `FCDO_OFF_2AA && same && code == `FCDO_C_SECTOR) begin
						set_prot = SECTOR_PROTECTED_IN;
						next_s.ers = !SECTOR_PROTECTED_IN;
					end else if (off == `FCDO_OFF_2AA && same && code == `FCDO_C_CHIP) begin
						set_prot = SECTOR_PROTECTED_IN;
						next_s.chip = !SECTOR_PROTECTED_IN;
					end else begin
						next_s.mode = MODE_ARRAY;
					end
				end
				ST_PROT1: begin
					if (off == `FCDO_OFF_2AA && code == `FCDO_C_PROTECT)
						next_s.st = ST_PROT2;
					else
						next_s.mode = MODE_ARRAY;
				end
				ST_PROT2: begin
					next_s.sector = sec;
					if (code == `FCDO_C_PROTECT) begin
						next_s.prot = 1'b1;
					end else if (code == `FCDO_C_RANGE) begin
						next_s.range_lo = sec;
						next_s.st = ST_RANGE;
					end else begin
						next_s.mode = MODE_ARRAY;
					end
				end
				ST_RANGE: begin
					// range is taken once per reset, lower sector first
					if (code == `FCDO_C_RANGE && !s.range_used && sec >= s.range_lo) begin
						next_s.sector = sec;
						next_s.lrange = 1'b1;
						next_s.range_used = 1'b1;
					end else begin
						next_s.mode = MODE_ARRAY;
					end
				end
				default: begin
					next_s.st = ST_IDLE;
				end
			endcase
		end
		next_s.fail_prot = (s.fail_prot && !clr) || set_prot;
		next_s.fail_prog = (s.fail_prog && !clr) || set_prog;
		next_s.rd_act = rd;
		next_s.dq_oe = rd;
		if (s.rd_act && !rd)
			next_s.stat_pend = 1'b0;
		if (rd) begin
			if (s.stat_pend)
				next_s.dq = {8'h00, STATUS_OUT};
			else if (otp_rd)
				next_s.dq = otp_q;
			else
				next_s.dq = ARRAY_DATA_IN;
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN)
			s <= '0;
		else if (CLOCK_EN_IN)
			s <= next_s;
	end

	always_comb begin
		STATUS_OUT = 8'h00;
		STATUS_OUT[`FCDO_ST_READY] = !BUSY_IN;
		STATUS_OUT[`FCDO_ST_PFAIL] = s.fail_prog;
		STATUS_OUT[`FCDO_ST_PROT] = s.fail_prot;
	end
	assign DQ_OUT           = s.dq;
	assign DQ_OE_OUT        = s.dq_oe;
	assign MODE_OUT         = s.mode;
	assign SECTOR_OUT       = s.sector;
	assign RANGE_LOW_OUT    = s.range_lo;
	assign BUF_WR_OUT       = s.bwr;
	assign BUF_ADDR_OUT     = s.baddr;
	assign BUF_DATA_OUT     = s.bdata;
	assign BUF_COUNT_OUT    = s.n;
	assign PROGRAM_OUT      = s.prog;
	assign ERASE_SECTOR_OUT = s.ers;
	assign ERASE_CHIP_OUT   = s.chip;
	assign SUSPEND_OUT      = s.susp;
	assign RESUME_OUT       = s.res;
	assign BLANK_CHECK_OUT  = s.blank;
	assign PROTECT_OUT      = s.prot;
	assign LOCK_RANGE_OUT   = s.lrange;

	idle_reset_a: assert property (@(posedge CLOCK_IN)
		RESET_IN |=> s.st == ST_IDLE && MODE_OUT == MODE_ARRAY)
		else $error("reset did not return to idle");
	prot_refuse_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		w && s.st == ST_ERASE && SECTOR_PROTECTED_IN && code inside {`FCDO_C_SECTOR, `FCDO_C_CHIP}
		&& same && off == `FCDO_OFF_2AA |=> STATUS_OUT[1] && !ERASE_SECTOR_OUT && !ERASE_CHIP_OUT)
		else $error("protected erase started");
	prot_sticky_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		STATUS_OUT[1] && !clr |=> STATUS_OUT[1])
		else $error("protect status dropped");
	otp_busy_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		BUSY_IN && MODE_OUT != MODE_OTP |=> MODE_OUT != MODE_OTP)
		else $error("region entered while busy");
	load_bound_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		s.st == ST_LOAD |-> s.idx <= s.n && s.n <= 5'h1F)
		else $error("buffer index beyond count");
	erase_go_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		CLOCK_EN_IN && w && s.st == ST_ERASE && same && off == `FCDO_OFF_2AA
		&& code == `FCDO_C_SECTOR && !SECTOR_PROTECTED_IN |=> ERASE_SECTOR_OUT ##1 !ERASE_SECTOR_OUT)
		else $error("sector erase not issued once");
	abort_seq_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		CLOCK_EN_IN && w && s.st == ST_PROT1 && code != `FCDO_C_PROTECT
		|=> s.st == ST_IDLE && MODE_OUT == MODE_ARRAY)
		else $error("bad write did not abort");
	status_read_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		CLOCK_EN_IN && rd && s.stat_pend |=> DQ_OUT[7:0] == $past(STATUS_OUT) && DQ_OE_OUT)
		else $error("status not returned");
endmodule
`default_nettype wire

// ### verif/fcdo_host.sv
// host memory controller model: multiplexed bus write and read cycles
`timescale 1ns/1ps
`default_nettype none
module fcdo_host (
	input  wire logic        clk_in,
	input  wire logic [15:0] rd_data_in,
	input  wire logic        rd_oe_in,
	output var logic         ce_n_out,
	output var logic         we_n_out,
	output var logic         oe_n_out,
	output var logic [22:0]  addr_out,
	output var logic [15:0]  dq_out
);
	initial begin
		ce_n_out = 1'h1;
		we_n_out = 1'h1;
		oe_n_out = 1'h1;
		addr_out = 23'h0;
		dq_out = 16'h0;
	end
	// strobes low across two sampled edges; released data flips so stale values never pass
	task automatic wr(input logic [22:0] a, input logic [15:0] d);
		@(posedge clk_in);
		ce_n_out <= 1'h0;
		we_n_out <= 1'h0;
		addr_out <= a;
		dq_out <= d;
		repeat (2) @(posedge clk_in);
		ce_n_out <= 1'h1;
		we_n_out <= 1'h1;
		dq_out <= ~d;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic rd(input logic [22:0] a, output logic [15:0] d, output logic oe);
		@(posedge clk_in);
		ce_n_out <= 1'h0;
		oe_n_out <= 1'h0;
		addr_out <= a;
		repeat (2) @(posedge clk_in);
		#1;
		d = rd_data_in;
		oe = rd_oe_in;
		@(posedge clk_in);
		ce_n_out <= 1'h1;
		oe_n_out <= 1'h1;
		@(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ### verif/fcdo_decoder_tb.sv
// self-checking bench of the flash command decoder
`timescale 1ns/1ps
`default_nettype none
module fcdo_decoder_tb;
	import fcdo_pkg::*;
	// serial id value is arbitrary
	localparam logic [127:0] SID = 128'hA1B2_C3D4_E5F6_0718_293A_4B5C_6D7E_8F90;
	localparam logic [9:0]   S   = 10'h2A5;
	localparam logic [15:0]  ARR = 16'h5A5A;
	logic        clk, rst, por, ce, busy, prot, pfail, ce_n, we_n, oe_n, dq_oe, rdoe;
	logic [1:0]  lkset, lk;
	logic [22:0] addr, baddr;
	logic [15:0] dq, dq_o, bdata, rdd;
	logic [9:0]  sec, rlow;
	wire  [8:0]  pv;
	logic [7:0]  status;
	logic [4:0]  bcnt;
	fcdo_mode_t  mode;
	int          cnt[9];
	int          bad_count, n_compared;
	fcdo_decoder #(.SERIAL_ID(SID)) u_fcdo_decoder (.CLOCK_IN(clk), .RESET_IN(rst),
		.POWER_ON_IN(por), .CLOCK_EN_IN(ce), .CE_N_IN(ce_n), .WE_N_IN(we_n), .OE_N_IN(oe_n),
		.ADDR_IN(addr), .DQ_IN(dq), .ARRAY_DATA_IN(ARR), .BUSY_IN(busy),
		.SECTOR_PROTECTED_IN(prot), .PROGRAM_FAIL_IN(pfail), .OTP_LOCK_SET_IN(lkset),
		.DQ_OUT(dq_o), .DQ_OE_OUT(dq_oe), .MODE_OUT(mode), .SECTOR_OUT(sec),
		.RANGE_LOW_OUT(rlow), .BUF_WR_OUT(pv[8]), .BUF_ADDR_OUT(baddr), .BUF_DATA_OUT(bdata),
		.BUF_COUNT_OUT(bcnt), .PROGRAM_OUT(pv[0]), .ERASE_SECTOR_OUT(pv[1]),
		.ERASE_CHIP_OUT(pv[2]), .SUSPEND_OUT(pv[3]), .RESUME_OUT(pv[4]),
		.BLANK_CHECK_OUT(pv[5]), .PROTECT_OUT(pv[6]), .LOCK_RANGE_OUT(pv[7]),
		.STATUS_OUT(status), .OTP_LOCK_OUT(lk));
	fcdo_host u_fcdo_host (.clk_in(clk), .rd_data_in(dq_o), .rd_oe_in(dq_oe), .ce_n_out(ce_n),
		.we_n_out(we_n), .oe_n_out(oe_n), .addr_out(addr), .dq_out(dq));
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		for (int i = 0; i < 9; i++) if (pv[i] === 1'h1) cnt[i]++;
	end
	function automatic logic [22:0] at(input logic [9:0] s, input logic [12:0] o);
		return {s, o};
	endfunction
	task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// pulse counts are cleared here (cnt[0] also in t_otp), when the bus has been quiet for cycles
	task automatic chkp(input int i, input int n);
		chk($sformatf("pulse%0d", i), 23'(n), 23'(cnt[i]));
		cnt[i] = 0;
	endtask
	task automatic w(input logic [22:0] a, input logic [15:0] d);
		u_fcdo_host.wr(a, d);
	endtask
	task automatic rdc(input logic [22:0] a, input logic [15:0] e);
		u_fcdo_host.rd(a, rdd, rdoe);
		chk("read", 23'(e), 23'(rdd));
		chk("read_oe", 23'h1, 23'(rdoe));
	endtask
	task automatic t_buffer;
		w(at(S, 13'h555), 16'h25);
		w(at(S, 13'h2AA), 16'h2);
		for (int i = 0; i < 3; i++) w(at(S, 13'h100 + 13'(i)), 16'hC0 + 16'(i));
		w(at(S, 13'h555), 16'h29);
		chkp(8, 3);
		chkp(0, 1);
		chk("count", 23'h2, 23'(bcnt));
		chk("sector", 23'(S), 23'(sec));
		chk("baddr", at(S, 13'h102), baddr);
		chk("bdata", 23'hC2, 23'(bdata));
		$display("buffer program test done");
	endtask
	task automatic t_single;
		w(at(S, 13'h555), 16'h80);
		w(at(S, 13'h2AA), 16'h30);
		chkp(1, 1);
		w(at(S, 13'h555), 16'h80);
		w(at(S, 13'h2AA), 16'h10);
		chkp(2, 1);
		w(at(S, 13'h1234), 16'hB0);
		chkp(3, 1);
		w(at(S, 13'h0), 16'h30);
		chkp(4, 1);
		w(at(S, 13'h555), 16'h33);
		chkp(5, 1);
		w(at(S, 13'h555), 16'h60);
		w(at(S, 13'h2AA), 16'h60);
		w(at(S, 13'h0), 16'h60);
		chkp(6, 1);
		w(at(S, 13'h555), 16'h60);
		w(at(S, 13'h2AA), 16'h60);
		w(at(10'h10, 13'h0), 16'h61);
		w(at(10'h20, 13'h0), 16'h61);
		chkp(7, 1);
		chk("range_low", 23'h10, 23'(rlow));
		$display("single command test done");
	endtask
	task automatic t_status;
		@(posedge clk) prot <= 1'h1;
		w(at(S, 13'h555), 16'h80);
		w(at(S, 13'h2AA), 16'h30);
		@(posedge clk) prot <= 1'h0;
		chkp(1, 0);
		chk("status", 23'h82, 23'(status));
		@(posedge clk) pfail <= 1'h1;
		@(posedge clk) pfail <= 1'h0;
		@(posedge clk);
		w(at(S, 13'h555), 16'h70);
		rdc(at(S, 13'h0), 16'h92);
		w(at(S, 13'h555), 16'h71);
		chk("status", 23'h80, 23'(status));
		$display("status test done");
	endtask
	task automatic t_otp;
		w(at(10'h0, 13'h555), 16'h88);
		chk("mode", 23'(MODE_OTP), 23'(mode));
		rdc(at(10'h0, 13'h0), SID[15:0]);
		rdc(at(10'h0, 13'h7), SID[127:112]);
		rdc(at(10'h0, 13'h80), 16'hFFFF);
		w(at(10'h0, 13'h555), 16'h25);
		w(at(10'h0, 13'h2AA), 16'h0);
		w(at(10'h0, 13'h1), 16'h0);
		w(at(10'h0, 13'h555), 16'h29);
		chk("status", 23'h82, 23'(status));
		rdc(at(10'h0, 13'h1), SID[31:16]);
		chkp(8, 0);
		w(at(S, 13'h3), 16'hF0);
		chk("mode", 23'(MODE_ARRAY), 23'(mode));
		rdc(at(10'h0, 13'h0), ARR);
		w(at(S, 13'h555), 16'h71);
		cnt[0] = 0;
		$display("secured region test done");
	endtask
	task automatic t_modes;
		w(at(S, 13'h1A55), 16'h90);
		chk("mode", 23'(MODE_ID), 23'(mode));
		w(at(S, 13'h0), 16'h12);
		chk("mode", 23'(MODE_ARRAY), 23'(mode));
		w(at(S, 13'h0B55), 16'h98);
		chk("mode", 23'(MODE_CFI), 23'(mode));
		w(at(S, 13'h7), 16'hF0);
		chk("mode", 23'(MODE_ARRAY), 23'(mode));
		// a whole write cycle while frozen must leave no trace
		@(posedge clk) ce <= 1'h0;
		w(at(S, 13'h1A55), 16'h90);
		@(posedge clk) ce <= 1'h1;
		repeat (2) @(posedge clk);
		chk("mode", 23'(MODE_ARRAY), 23'(mode));
		@(posedge clk) busy <= 1'h1;
		w(at(10'h0, 13'h555), 16'h88);
		chk("mode", 23'(MODE_ARRAY), 23'(mode));
		chk("status", 23'h0, 23'(status));
		@(posedge clk) busy <= 1'h0;
		$display("mode test done");
	endtask
	task automatic t_lock;
		@(posedge clk) lkset <= 2'h1;
		@(posedge clk) lkset <= 2'h0;
		w(at(S, 13'h555), 16'h25);
		@(posedge clk) rst <= 1'h1;
		@(posedge clk) rst <= 1'h0;
		repeat (2) @(posedge clk);
		chk("lock", 23'h3, 23'(lk));
		w(at(S, 13'h2AA), 16'h0);
		w(at(S, 13'h1), 16'h1);
		chkp(8, 0);
		chk("mode", 23'(MODE_ARRAY), 23'(mode));
		$display("lock and reset test done");
	endtask
	task automatic summarize;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		summarize();
	end
	initial begin
		{rst, por, ce, busy, prot, pfail, lkset} = {1'h1, 1'h1, 1'h1, 5'h0};
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		por <= 1'h0;
		repeat (2) @(posedge clk);
		chk("mode", 23'(MODE_ARRAY), 23'(mode));
		chk("lock", 23'h2, 23'(lk));
		chk("status", 23'h80, 23'(status));
		t_buffer();
		t_single();
		t_status();
		t_otp();
		t_modes();
		t_lock();
		summarize();
	end
endmodule
`default_nettype wire
